/* File: dfseq_pkg.sv */
/*
  Package for the data-flash command sequencer: register offsets, field
  positions, reset values, command codes, timing counts and carrier types.
  Assumes a 32-bit classic Wishbone register bus and a 100 MHz clock.
*/
package dfseq_pkg;
  // ==========================================================================
  // Register map (byte addresses, one aligned word each).
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_ERRSTAT = 8'h04;
  localparam logic [7:0] ADDR_CONFIG = 8'h08;
  localparam logic [7:0] ADDR_ERRCFG = 8'h0C;
  localparam logic [7:0] ADDR_INDEX = 8'h10;
  localparam logic [7:0] ADDR_DATA = 8'h14;
  localparam logic [7:0] ADDR_MARGIN = 8'h18;
  // ==========================================================================
  // Field positions.
  localparam int BIT_CCF = 7;
  localparam int BIT_ACC = 5;
  localparam int BIT_PV = 4;
  localparam int BIT_VHI = 1;
  localparam int BIT_VLO = 0;
  localparam int BIT_DFLT = 1;
  localparam int BIT_SFLT = 0;
  localparam int BIT_CMD_IRQ_EN = 7;
  localparam int BIT_SPECIAL = 0;
  // ==========================================================================
  // Command codes and slot indices.
  localparam logic [7:0] CMD_FIELD_MARGIN = 8'h0E;
  localparam logic [7:0] CMD_SECT_VERIFY = 8'h10;
  localparam logic [7:0] CMD_PROGRAM = 8'h11;
  localparam logic [7:0] CMD_SECT_ERASE = 8'h12;
  localparam logic [2:0] IDX_0 = 3'b000;
  localparam logic [2:0] IDX_1 = 3'b001;
  localparam logic [2:0] IDX_2 = 3'b010;
  localparam logic [2:0] IDX_5 = 3'b101;
  localparam logic [15:0] MARGIN_MAX = 16'h0004;
  // ==========================================================================
  // Data-flash geometry and block selector.
  localparam logic [1:0] DF_BLOCK_SEL = 2'b01;
  localparam logic [1:0] PF_BLOCK_SEL = 2'b11;
  localparam logic [15:0] DF_BASE = 16'h4000;
  localparam logic [15:0] DF_END = 16'h4800;
  localparam logic [15:0] SECTOR_MASK = 16'hFFFC;
  localparam logic [7:0] STATUS_RESET = 8'h80;
  // Flash array times in ns and derived cycle counts.
  localparam int CLK_NS = 10;
  localparam int T_PROG_NS = 20000;
  localparam int T_ERASE_NS = 40000;
  localparam int PROG_CYC = (T_PROG_NS + CLK_NS - 1) / CLK_NS;
  localparam int ERASE_CYC = (T_ERASE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [15:0] WORD_ERASED = 16'hFFFF;

  typedef enum logic [2:0] {ST_IDLE, ST_CHECK, ST_OP, ST_VERIFY, ST_DONE} seq_state_e;

  typedef struct packed {
    logic cc;
    logic acc;
    logic pv;
    logic vhi;
    logic vlo;
  } status_s;

  typedef struct packed {
    logic [2:0] margin_df;
    logic [2:0] margin_pf;
  } margin_s;
endpackage

/* File: dfseq.sv */
/*
  Data-flash command sequencer with a classic Wishbone register slave.
  Assumes the flash array sits outside: read port with ECC fault strobes,
  and program and erase strobes. Protection and mode are plain inputs.
*/
`timescale 1ns/1ps
module dfseq
  import dfseq_pkg::*;
(
  input wire logic clk, // System clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic ce, // Clock enable, freezes state when low.
  input wire logic [7:0] wb_adr_i, // Wishbone byte address.
  input wire logic [31:0] wb_dat_i, // Wishbone write data.
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects.
  input wire logic wb_we_i, // Wishbone write enable.
  input wire logic wb_cyc_i, // Wishbone cycle.
  input wire logic wb_stb_i, // Wishbone strobe.
  output logic [31:0] wb_dat_o, // Wishbone read data.
  output logic wb_ack_o, // Wishbone acknowledge.
  input wire logic special_mode, // High in special operating modes.
  input wire logic area_protected, // Target area is protected.
  output logic [15:0] fl_addr, // Flash word address.
  output logic [15:0] fl_wdata, // Flash program data.
  output logic fl_rd, // Flash read strobe.
  output logic fl_prog, // Flash program strobe.
  output logic fl_erase, // Flash sector erase strobe.
  input wire logic [15:0] fl_rdata, // Flash read data.
  input wire logic fl_sbe, // Single-bit ECC fault on read.
  input wire logic fl_dbe, // Double-bit ECC fault on read.
  output margin_s margin, // Read margin levels for each array.
  output logic cmd_irq, // Command-complete interrupt request.
  output logic err_irq // ECC fault interrupt request.
);
  // ==========================================================================
  // Storage.
  logic [15:0] slot_q [0:5];
  logic [2:0] param_slot_index_q;
  logic [2:0] launch_idx_q;
  status_s st_q;
  logic double_fault_flag_q, single_fault_flag_q;
  logic cmd_complete_irq_en_q, double_fault_irq_en_q, single_fault_irq_en_q;
  margin_s margin_q;
  seq_state_e state_q;
  logic [15:0] cnt_q;
  logic [15:0] addr_q;
  logic [2:0] words_q;
  logic [2:0] widx_q;
  logic ack_q;
  logic [31:0] rdat_q;

  // ==========================================================================
  // Bus decode. Writes to slots are ignored while a command is running.
  wire bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
  wire bus_wr = bus_req & wb_we_i & wb_sel_i[0];
  wire wr_status = bus_wr && wb_adr_i == ADDR_STATUS;
  wire wr_errstat = bus_wr && wb_adr_i == ADDR_ERRSTAT;
  wire wr_config = bus_wr && wb_adr_i == ADDR_CONFIG;
  wire wr_errcfg = bus_wr && wb_adr_i == ADDR_ERRCFG;
  wire wr_index = bus_wr && wb_adr_i == ADDR_INDEX && st_q.cc;
  wire wr_data = bus_req && wb_we_i && wb_adr_i == ADDR_DATA && st_q.cc;
  wire launch = wr_status && st_q.cc && wb_dat_i[BIT_CCF];
  wire [7:0] status_rd = {st_q.cc, 1'b0, st_q.acc, st_q.pv, 2'b00, st_q.vhi, st_q.vlo};
  wire [31:0] rd_mux =
    (wb_adr_i == ADDR_STATUS) ? {24'h00_0000, status_rd} :
    (wb_adr_i == ADDR_ERRSTAT) ? {30'h0000_0000, double_fault_flag_q, single_fault_flag_q} :
    (wb_adr_i == ADDR_CONFIG) ? {24'h00_0000, cmd_complete_irq_en_q, 7'h00} :
    (wb_adr_i == ADDR_ERRCFG) ? {30'h0000_0000, double_fault_irq_en_q, single_fault_irq_en_q} :
    (wb_adr_i == ADDR_INDEX) ? {29'h0000_0000, param_slot_index_q} :
    (wb_adr_i == ADDR_DATA) ? {16'h0000, slot_q[param_slot_index_q]} :
    (wb_adr_i == ADDR_MARGIN) ? {26'h000_0000, margin_q} : 32'h0000_0000;

  // ==========================================================================
  // Launch checks, all evaluated on the slot contents at launch.
  wire [7:0] cmd = slot_q[0][15:8];
  wire [1:0] blk = slot_q[0][1:0];
  wire [15:0] a1 = slot_q[1];
  wire df_addr_ok = a1 >= DF_BASE && a1 < DF_END;
  wire [16:0] sect_end = {1'b0, a1} + {slot_q[2], 1'b0};
  wire [16:0] grp_end = {1'b0, a1} + {13'h0000, launch_idx_q - IDX_1, 1'b0};
  wire [15:0] mval = slot_q[1];
  wire acc_margin = launch_idx_q != IDX_1 || !special_mode
    || (blk != DF_BLOCK_SEL && blk != PF_BLOCK_SEL) || mval > MARGIN_MAX;
  wire acc_verify = launch_idx_q != IDX_2 || !(blk == DF_BLOCK_SEL) || !df_addr_ok
    || a1[0] || sect_end > {1'b0, DF_END};
  wire acc_prog = launch_idx_q < IDX_2 || launch_idx_q > IDX_5 || blk != DF_BLOCK_SEL
    || !df_addr_ok || a1[0] || grp_end > {1'b0, DF_END};
  wire acc_erase = launch_idx_q != IDX_1 || blk != DF_BLOCK_SEL || !df_addr_ok || a1[0];
  wire acc_any =
    (cmd == CMD_FIELD_MARGIN) ? acc_margin :
    (cmd == CMD_SECT_VERIFY) ? acc_verify :
    (cmd == CMD_PROGRAM) ? acc_prog :
    (cmd == CMD_SECT_ERASE) ? acc_erase : 1'b1;
  wire needs_prot = cmd == CMD_PROGRAM || cmd == CMD_SECT_ERASE;
  wire rd_err = fl_sbe | fl_dbe | (fl_rdata != WORD_ERASED);
  wire prog_err = fl_sbe | fl_dbe | (fl_rdata != slot_q[widx_q]);
  wire vfy_err = (cmd == CMD_PROGRAM) ? prog_err : rd_err;

  // ==========================================================================
  // Register bus slave and software controls.
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
      param_slot_index_q <= IDX_0;
      cmd_complete_irq_en_q <= 1'b0;
      double_fault_irq_en_q <= 1'b0;
      single_fault_irq_en_q <= 1'b0;
    end
    else if (ce)
    begin
      ack_q <= bus_req;
      rdat_q <= rd_mux;
      if (wr_index) param_slot_index_q <= wb_dat_i[2:0];
      if (wr_config) cmd_complete_irq_en_q <= wb_dat_i[BIT_CMD_IRQ_EN];
      if (wr_errcfg)
      begin
        double_fault_irq_en_q <= wb_dat_i[BIT_DFLT];
        single_fault_irq_en_q <= wb_dat_i[BIT_SFLT];
      end
    end

  // Parameter slots, written through the indexed data register.
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      for (int i = 0; i < 6; i++) slot_q[i] <= 16'h0000;
    end
    else if (ce && wr_data && param_slot_index_q <= IDX_5)
    begin
      if (wb_sel_i[0]) slot_q[param_slot_index_q][7:0] <= wb_dat_i[7:0];
      if (wb_sel_i[1]) slot_q[param_slot_index_q][15:8] <= wb_dat_i[15:8];
    end

  // ==========================================================================
  // ECC fault flags: a fault in the clearing cycle keeps its flag set.
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      double_fault_flag_q <= 1'b0;
      single_fault_flag_q <= 1'b0;
    end
    else if (ce)
    begin
      double_fault_flag_q <= (fl_rd & fl_dbe) | (double_fault_flag_q & ~(wr_errstat & wb_dat_i[BIT_DFLT]));
      single_fault_flag_q <= (fl_rd & fl_sbe) | (single_fault_flag_q & ~(wr_errstat & wb_dat_i[BIT_SFLT]));
    end

  // ==========================================================================
  // Command sequencer. Flash strobes are one-cycle pulses; the array answers
  // reads combinationally in the same cycle as fl_rd.
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      state_q <= ST_IDLE;
      st_q <= STATUS_RESET[7:3];
      launch_idx_q <= IDX_0;
      margin_q <= '0;
      cnt_q <= 16'h0000;
      addr_q <= 16'h0000;
      words_q <= 3'd0;
      widx_q <= 3'd0;
      fl_rd <= 1'b0;
      fl_prog <= 1'b0;
      fl_erase <= 1'b0;
      fl_addr <= 16'h0000;
      fl_wdata <= 16'h0000;
    end
    else if (ce)
    begin
      fl_rd <= 1'b0;
      fl_prog <= 1'b0;
      fl_erase <= 1'b0;
      if (wr_status && wb_dat_i[BIT_ACC]) st_q.acc <= 1'b0;
      if (wr_status && wb_dat_i[BIT_PV]) st_q.pv <= 1'b0;
      case (state_q)
        ST_IDLE:
          if (launch && !st_q.acc && !st_q.pv)
          begin
            st_q.cc <= 1'b0;
            st_q.vhi <= 1'b0;
            st_q.vlo <= 1'b0;
            launch_idx_q <= param_slot_index_q;
            state_q <= ST_CHECK;
          end
        ST_CHECK:
          if (acc_any)
          begin
            st_q.acc <= 1'b1;
            state_q <= ST_DONE;
          end
          else if (needs_prot && area_protected)
          begin
            st_q.pv <= 1'b1;
            state_q <= ST_DONE;
          end
          else if (cmd == CMD_FIELD_MARGIN)
          begin
            if (blk == DF_BLOCK_SEL) margin_q.margin_df <= mval[2:0];
            else
            begin
              margin_q.margin_df <= mval[2:0];
              margin_q.margin_pf <= mval[2:0];
            end
            state_q <= ST_DONE;
          end
          else
          begin
            widx_q <= IDX_2;
            if (cmd == CMD_SECT_VERIFY)
            begin
              addr_q <= a1;
              words_q <= 3'd0;
              cnt_q <= slot_q[2];
              state_q <= ST_VERIFY;
            end
            else if (cmd == CMD_PROGRAM)
            begin
              addr_q <= a1;
              words_q <= launch_idx_q - IDX_1;
              cnt_q <= 16'(PROG_CYC);
              fl_addr <= a1;
              fl_wdata <= slot_q[IDX_2];
              fl_prog <= 1'b1;
              state_q <= ST_OP;
            end
            else
            begin
              addr_q <= a1 & SECTOR_MASK;
              cnt_q <= 16'(ERASE_CYC);
              fl_addr <= a1 & SECTOR_MASK;
              fl_erase <= 1'b1;
              state_q <= ST_OP;
            end
          end
        ST_OP:
          if (cnt_q > 16'h0001) cnt_q <= cnt_q - 16'h0001;
          else if (cmd == CMD_PROGRAM && words_q > 3'd1)
          begin
            words_q <= words_q - 3'd1;
            widx_q <= widx_q + 3'd1;
            fl_addr <= fl_addr + 16'h0002;
            fl_wdata <= slot_q[widx_q + 3'd1];
            fl_prog <= 1'b1;
            cnt_q <= 16'(PROG_CYC);
          end
          else
          begin
            widx_q <= IDX_2;
            cnt_q <= (cmd == CMD_PROGRAM) ? {13'h0000, launch_idx_q - IDX_1} : 16'h0004;
            fl_addr <= addr_q;
            fl_rd <= 1'b1;
            words_q <= 3'd1;
            state_q <= ST_VERIFY;
          end
        ST_VERIFY:
          // words_q flags a read outstanding in the previous cycle.
          if (words_q == 3'd0 && cnt_q != 16'h0000)
          begin
            fl_addr <= addr_q;
            fl_rd <= 1'b1;
            words_q <= 3'd1;
          end
          else if (words_q == 3'd0)
            state_q <= ST_DONE;
          else
          begin
            if (vfy_err) st_q.vhi <= 1'b1;
            if (fl_dbe) st_q.vlo <= 1'b1;
            cnt_q <= cnt_q - 16'h0001;
            addr_q <= fl_addr + 16'h0002;
            widx_q <= widx_q + 3'd1;
            words_q <= 3'd0;
          end
        ST_DONE:
        begin
          st_q.cc <= 1'b1;
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end

  // ==========================================================================
  // Registered outputs; interrupts follow flag and enable by one cycle.
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      cmd_irq <= 1'b0;
      err_irq <= 1'b0;
      margin <= '0;
    end
    else if (ce)
    begin
      cmd_irq <= st_q.cc & cmd_complete_irq_en_q;
      err_irq <= (double_fault_flag_q & double_fault_irq_en_q) | (single_fault_flag_q & single_fault_irq_en_q);
      margin <= margin_q;
    end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // ==========================================================================
  // Checks.
  a_launch_clears: assert property (@(posedge clk) disable iff (rst)
    ce && state_q == ST_IDLE && launch && !st_q.acc && !st_q.pv |=> !st_q.cc)
    else $error("complete flag not cleared on launch");
  a_margin_mode: assert property (@(posedge clk) disable iff (rst)
    ce && state_q == ST_CHECK && cmd == CMD_FIELD_MARGIN && !special_mode |=> st_q.acc)
    else $error("margin command accepted outside special mode");
  a_df_margin_only: assert property (@(posedge clk) disable iff (rst)
    ce && state_q == ST_CHECK && !acc_any && cmd == CMD_FIELD_MARGIN && blk == DF_BLOCK_SEL
    |=> $stable(margin_q.margin_pf))
    else $error("data margin changed program margin");
  a_pv_no_prog: assert property (@(posedge clk) disable iff (rst)
    ce && state_q == ST_CHECK && !acc_any && needs_prot && area_protected |=> !fl_prog && st_q.pv)
    else $error("protected area programmed");
  a_verify_noviol: assert property (@(posedge clk) disable iff (rst)
    ce && state_q == ST_CHECK && cmd == CMD_SECT_VERIFY |=> $stable(st_q.pv))
    else $error("verify changed violation flag");
  a_cmd_irq_lvl: assert property (@(posedge clk) disable iff (rst)
    ce |=> cmd_irq == $past(st_q.cc & cmd_complete_irq_en_q))
    else $error("command interrupt mismatch");
  a_err_irq_lvl: assert property (@(posedge clk) disable iff (rst)
    ce && !double_fault_irq_en_q && !single_fault_irq_en_q |=> !err_irq)
    else $error("error interrupt without enable");
  a_bad_index: assert property (@(posedge clk) disable iff (rst)
    ce && state_q == ST_CHECK && cmd == CMD_PROGRAM && launch_idx_q < IDX_2 |=> st_q.acc ##1 st_q.cc)
    else $error("bad program index accepted");
endmodule // dfseq

/* File: test_dfseq.sv */
/*
  Self-checking bench for the data-flash command sequencer, driven over classic Wishbone.
  Assumes the dfseq module and its package; the bench stands in for the flash array itself.
*/
`timescale 1ns/1ps
module test_dfseq;
  import dfseq_pkg::*;
  `define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_total++; $display("FAIL %0t got %h exp %h", $time, g, e); end end
  // ==========================================================================
  // Stimulus and observation signals.
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic [31:0] rdat;
  logic ack;
  logic spec = 1'b0;
  logic prot = 1'b0;
  logic sbe = 1'b0;
  logic dbe = 1'b0;
  logic [15:0] flip = 16'h0000;
  logic [15:0] fa;
  logic [15:0] fw;
  logic frd;
  logic fprog;
  logic ferase;
  logic [15:0] mem [16];
  margin_s mg;
  logic cirq;
  logic eirq;
  int err_total = 0;
  int samples_checked = 0;
  int nprog = 0;
  int nerase = 0;
  int nrd = 0;
  logic [15:0] ea = 16'h0000;
  int k;
  logic [15:0] wq [$];
  logic [7:0] st;
  logic [7:0] st0;
  logic irq0;
  logic [31:0] q;
  // Refused launches: command, address and index at launch.
  logic [7:0] tc [11] = '{8'h10, 8'h10, 8'h10, 8'h10, 8'h11, 8'h11, 8'h11, 8'h11, 8'h12, 8'h12, 8'h12};
  logic [15:0] ta [11] = '{16'h4001, 16'h3FFE, 16'h47FA, 16'h4000, 16'h4000, 16'h4000, 16'h4005, 16'h47FC,
    16'h4005, 16'h4004, 16'h3FFE};
  logic [2:0] ti [11] = '{3'h2, 3'h2, 3'h2, 3'h1, 3'h6, 3'h1, 3'h2, 3'h4, 3'h1, 3'h2, 3'h1};

  always #5 clk = ~clk;

  dfseq DUT (.clk(clk), .rst(rst), .ce(1'b1), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_we_i(we),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack), .special_mode(spec), .area_protected(prot),
    .fl_addr(fa), .fl_wdata(fw), .fl_rd(frd), .fl_prog(fprog), .fl_erase(ferase), .fl_rdata(mem[fa[3:0]] ^ flip),
    .fl_sbe(sbe), .fl_dbe(dbe), .margin(mg), .cmd_irq(cirq), .err_irq(eirq));

  // ==========================================================================
  // Flash array model. Addresses alias into 16 words; erase blanks them all, which is enough here.
  always @(posedge clk)
  begin
    if (frd === 1'b1)
      nrd++;
    if (fprog === 1'b1)
    begin
      mem[fa[3:0]] <= fw;
      wq.push_back(fw);
      nprog++;
    end
    if (ferase === 1'b1)
    begin
      for (int i = 0; i < 16; i++)
        mem[i] <= 16'hFFFF;
      ea <= fa;
      nerase++;
    end
  end

  // ==========================================================================
  // Bus tasks. Ack is read before the edge's own updates land, so it is the sampled value.
  // A missing ack is left to the watchdog, so no wait ends silently.
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    adr <= a;
    we <= w;
    wdat <= d;
    do
    begin
      @(posedge clk);
    end
    while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(a, 1'b1, d, r);
  endtask

  task automatic slot(input logic [2:0] i, input logic [15:0] v);
    wr(ADDR_INDEX, {29'h0000_0000, i});
    wr(ADDR_DATA, {16'h0000, v});
  endtask

  // Clears stale errors, loads slots 0 and 1, sets the index, launches and polls for completion.
  task automatic run(input logic [7:0] c, input logic [1:0] b, input logic [15:0] a, input logic [2:0] ix);
    wr(ADDR_STATUS, 32'h0000_0030);
    slot(IDX_0, {c, 6'h00, b});
    slot(IDX_1, a);
    wr(ADDR_INDEX, {29'h0000_0000, ix});
    wr(ADDR_STATUS, 32'h0000_0080);
    wb(ADDR_STATUS, 1'b0, 32'h0000_0000, q);
    st0 = q[7:0];
    irq0 = cirq;
    while (q[7] !== 1'b1)
    begin
      wb(ADDR_STATUS, 1'b0, 32'h0000_0000, q);
    end
    st = q[7:0] & 8'hB3;
  endtask

  task automatic settle();
    repeat (2) @(posedge clk);
  endtask

  task automatic end_of_test();
    if (err_total == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ==========================================================================
  // Watchdog, set well above the roughly 17k cycles that the sequence needs.
  initial
  begin
    repeat (60000) @(posedge clk);
    err_total++;
    $display("FAIL %0t watchdog expired", $time);
    end_of_test();
  end

  // ==========================================================================
  // Main sequence.
  initial
  begin
    for (int i = 0; i < 16; i++)
      mem[i] = 16'hFFFF;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    wb(ADDR_STATUS, 1'b0, 32'h0000_0000, q);
    `CHK(q[7:0] & 8'hB3, STATUS_RESET)
    `CHK(mg, 6'h00)
    // Margin command: mode, index and selector refusals, then every level.
    run(CMD_FIELD_MARGIN, DF_BLOCK_SEL, 16'h0001, IDX_1);
    `CHK(st, 8'hA0)
    spec <= 1'b1;
    run(CMD_FIELD_MARGIN, DF_BLOCK_SEL, 16'h0001, IDX_0);
    `CHK(st, 8'hA0)
    run(CMD_FIELD_MARGIN, 2'b00, 16'h0001, IDX_1);
    `CHK(st, 8'hA0)
    for (int v = 0; v < 6; v++)
    begin
      run(CMD_FIELD_MARGIN, DF_BLOCK_SEL, v[15:0], IDX_1);
      `CHK(st, (v > 4) ? 8'hA0 : 8'h80)
      `CHK(mg.margin_df, (v > 4) ? 3'h4 : v[2:0])
      `CHK(mg.margin_pf, 3'h0)
    end
    run(CMD_FIELD_MARGIN, PF_BLOCK_SEL, 16'h0003, IDX_1);
    `CHK(mg, 6'h1B)
    run(CMD_FIELD_MARGIN, DF_BLOCK_SEL, 16'h0002, IDX_1);
    `CHK(mg, 6'h13)
    // Section verify on a protected area: clean, at the block end, with bad and uncorrectable reads.
    prot <= 1'b1;
    slot(IDX_2, 16'h0004);
    k = nrd;
    run(CMD_SECT_VERIFY, DF_BLOCK_SEL, 16'h4000, IDX_2);
    `CHK(st, 8'h80)
    `CHK(nrd - k, 4)
    run(CMD_SECT_VERIFY, DF_BLOCK_SEL, 16'h47F8, IDX_2);
    `CHK(st, 8'h80)
    flip <= 16'h0001;
    run(CMD_SECT_VERIFY, DF_BLOCK_SEL, 16'h4000, IDX_2);
    `CHK(st, 8'h82)
    flip <= 16'h0000;
    dbe <= 1'b1;
    run(CMD_SECT_VERIFY, DF_BLOCK_SEL, 16'h4000, IDX_2);
    `CHK(st, 8'h83)
    dbe <= 1'b0;
    sbe <= 1'b1;
    run(CMD_SECT_VERIFY, DF_BLOCK_SEL, 16'h4000, IDX_2);
    sbe <= 1'b0;
    wb(ADDR_ERRSTAT, 1'b0, 32'h0000_0000, q);
    `CHK(q[1:0], 2'b11)
    // Fault interrupts follow flag and enable, each on its own.
    `CHK(eirq, 1'b0)
    wr(ADDR_ERRCFG, 32'h0000_0001);
    settle();
    `CHK(eirq, 1'b1)
    wr(ADDR_ERRSTAT, 32'h0000_0001);
    settle();
    `CHK(eirq, 1'b0)
    wr(ADDR_ERRCFG, 32'h0000_0002);
    settle();
    `CHK(eirq, 1'b1)
    wr(ADDR_ERRSTAT, 32'h0000_0002);
    settle();
    `CHK(eirq, 1'b0)
    // Every refused launch leaves the array alone.
    prot <= 1'b0;
    for (int j = 0; j < 11; j++)
    begin
      k = nprog + nerase;
      run(tc[j], DF_BLOCK_SEL, ta[j], ti[j]);
      `CHK(st, 8'hA0)
      `CHK(nprog + nerase, k)
    end
    // Program three words; the count comes from the index at launch.
    slot(IDX_2, 16'h1234);
    slot(3'b011, 16'hA5A5);
    slot(3'b100, 16'h0F0F);
    wq.delete();
    k = nprog;
    run(CMD_PROGRAM, DF_BLOCK_SEL, 16'h4004, 3'b100);
    `CHK(st0[7], 1'b0)
    `CHK(st, 8'h80)
    `CHK(nprog - k, 3)
    `CHK((wq.size() == 3) ? {wq[0], wq[1], wq[2]} : 48'h0000_0000_0000, {16'h1234, 16'hA5A5, 16'h0F0F})
    // Protected program and erase write nothing and flag the violation.
    prot <= 1'b1;
    k = nprog + nerase;
    run(CMD_PROGRAM, DF_BLOCK_SEL, 16'h4010, IDX_2);
    `CHK(st, 8'h90)
    run(CMD_SECT_ERASE, DF_BLOCK_SEL, 16'h4006, IDX_1);
    `CHK(st, 8'h90)
    `CHK(nprog + nerase, k)
    // A word that reads back wrong is reported by the program verify.
    prot <= 1'b0;
    flip <= 16'h0100;
    run(CMD_PROGRAM, DF_BLOCK_SEL, 16'h4010, IDX_2);
    `CHK(st, 8'h82)
    flip <= 16'h0000;
    // Sector erase with the command interrupt enabled.
    wr(ADDR_CONFIG, 32'h0000_0080);
    k = nerase;
    run(CMD_SECT_ERASE, DF_BLOCK_SEL, 16'h4006, IDX_1);
    `CHK(st0[7], 1'b0)
    `CHK(irq0, 1'b0)
    `CHK(st, 8'h80)
    `CHK(nerase - k, 1)
    `CHK(ea, 16'h4004)
    settle();
    `CHK(cirq, 1'b1)
    wr(ADDR_CONFIG, 32'h0000_0000);
    settle();
    `CHK(cirq, 1'b0)
    flip <= 16'h0001;
    run(CMD_SECT_ERASE, DF_BLOCK_SEL, 16'h4006, IDX_1);
    `CHK(st, 8'h82)
    end_of_test();
  end
endmodule // test_dfseq
